// *** core/regulator_irq_params.svh ***
// Register map, field layout and reset constants of the regulator event masking block
`ifndef REGULATOR_IRQ_PARAMS_SVH
`define REGULATOR_IRQ_PARAMS_SVH

// Register addresses as seen over the serial port
`define CONV_MASK_ADDR 8'h22
`define LINREG_MASK_ADDR 8'h23

// Both mask registers come out of reset with every mask bit set
`define MASK_RESET 8'hDD
// Writable bits; bits 5 and 1 are reserved and always read as zero
`define MASK_WRITABLE 8'hDD
// Value returned for addresses this block does not own
`define UNMAPPED_READ 8'h00

// Field positions inside one regulator's nibble of a mask register
`define BIT_PG_FALL 3
`define BIT_PG_RISE 2
`define BIT_CURLIM 0
// Distance between the nibbles of regulator 0 and regulator 1
`define UNIT_STRIDE 4

// Regulator count and how many share one mask register
`define NUM_REGULATORS 4
`define UNITS_PER_REG 2

// Serial port framing
`define BYTE_BITS 4'd8
`define BIT_CNT_ZERO 4'd0
`define BIT_CNT_STEP 4'd1
`define PTR_STEP 8'h01

`endif

// *** core/regulator_irq_pkg.sv ***
// Types shared by the regulator event masking design
package regulator_irq_pkg;

    // One register byte
    typedef logic [7:0] byte_t;

    // Serial target states, Gray coded along the write path and the read data loop
    typedef enum logic [3:0] {
        ST_IDLE      = 4'h0,
        ST_ADDR      = 4'h1,
        ST_ADDR_ACK  = 4'h3,
        ST_REG       = 4'h2,
        ST_REG_ACK   = 4'h6,
        ST_WDATA     = 4'h7,
        ST_WDATA_ACK = 4'h5,
        ST_RDATA     = 4'h4,
        ST_RDATA_ACK = 4'hC
    } i2c_state_t;

endpackage

// *** core/regulator_event_if.sv ***
// Signals between the register block and one regulator's event detector
interface regulator_event_if;
    logic pg_raw;       // Power-good raw status, 1 while output invalid
    logic curlim_raw;   // Current limit raw status, 1 while limit active
    logic pg_fall_mask; // 1 blocks the invalid transition
    logic pg_rise_mask; // 1 blocks the valid transition
    logic curlim_mask;  // 1 blocks current limit detection
    logic pg_event;     // One-cycle power-good interrupt request
    logic curlim_event; // One-cycle current limit interrupt request

    // Register side
    modport ctrl (
        output pg_raw,
        output curlim_raw,
        output pg_fall_mask,
        output pg_rise_mask,
        output curlim_mask,
        input pg_event,
        input curlim_event
    );

    // Detector side
    modport det (
        input pg_raw,
        input curlim_raw,
        input pg_fall_mask,
        input pg_rise_mask,
        input curlim_mask,
        output pg_event,
        output curlim_event
    );
endinterface

// *** core/regulator_event_detect.sv ***
// Edge detection and mask gating for one regulator's events
module regulator_event_detect (
    input wire logic mclk,
    input wire logic sys_rst,
    regulator_event_if.det ev
);
    import regulator_irq_pkg::*;

    logic pg_prev;     // Raw power-good seen one cycle earlier
    logic curlim_prev; // Raw current limit seen one cycle earlier

    // History of the raw status; resets to the raw reset value of zero
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pg_prev <= 1'b0;
            curlim_prev <= 1'b0;
        end else begin
            pg_prev <= ev.pg_raw;
            curlim_prev <= ev.curlim_raw;
        end
    end

    // Mask is sampled at the moment of the edge, so a later mask write
    // neither creates nor removes a request already issued
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ev.pg_event <= 1'b0;
            ev.curlim_event <= 1'b0;
        end else begin
            // Either power-good direction feeds one request
            ev.pg_event <= (ev.pg_raw & ~pg_prev & ~ev.pg_fall_mask) |
                (~ev.pg_raw & pg_prev & ~ev.pg_rise_mask);
            // Only the onset of current limiting counts as detection
            ev.curlim_event <= ev.curlim_raw & ~curlim_prev & ~ev.curlim_mask;
        end
    end
endmodule // regulator_event_detect

// *** core/regulator_irq_mask.sv ***
// Regulator interrupt masking with its serial register target
`include "regulator_irq_params.svh"

module regulator_irq_mask #(
    // Seven-bit serial target address; the default is arbitrary
    parameter logic [6:0] DEV_ADDR = 7'h60
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic [`NUM_REGULATORS-1:0] pg_invalid_in,
    input wire logic [`NUM_REGULATORS-1:0] curlim_active_in,
    output logic conv0_pg_raw,
    output logic conv1_pg_raw,
    output logic linreg0_pg_raw,
    output logic linreg1_pg_raw,
    output logic conv0_curlim_raw,
    output logic conv1_curlim_raw,
    output logic linreg0_curlim_raw,
    output logic linreg1_curlim_raw,
    output logic conv0_pg_irq,
    output logic conv1_pg_irq,
    output logic linreg0_pg_irq,
    output logic linreg1_pg_irq,
    output logic conv0_curlim_irq,
    output logic conv1_curlim_irq,
    output logic linreg0_curlim_irq,
    output logic linreg1_curlim_irq,
    output regulator_irq_pkg::byte_t converter_irq_mask,
    output regulator_irq_pkg::byte_t linear_reg_irq_mask
);
    import regulator_irq_pkg::*;

    // Serial line history and derived conditions
    logic scl_q;      // Clock line one cycle ago
    logic sda_q;      // Data line one cycle ago
    logic scl_rise;   // Clock rising, data is sampled here
    logic scl_fall;   // Clock falling, data may change here
    logic bus_start;  // Start or repeated start
    logic bus_stop;   // Stop condition

    // Transfer state
    i2c_state_t state;      // Serial target state
    logic [3:0] bit_cnt;    // Bits seen in the current byte
    byte_t shift;           // Shift register for both directions
    byte_t reg_ptr;         // Register pointer, auto-incremented
    logic rw_read;          // Current transfer is a read
    logic master_ack;       // Host acknowledged the last read byte
    byte_t rd_byte;         // Value at the pointer
    logic reg_write;        // One-cycle write strobe

    // Regulator order in vectors: conv0, conv1, linreg0, linreg1
    byte_t mask_reg [`UNITS_PER_REG];       // Stored mask bits
    logic [`NUM_REGULATORS-1:0] pg_raw_q;   // Registered power-good status
    logic [`NUM_REGULATORS-1:0] curlim_raw_q; // Registered limit status

    // Inputs are synchronous to mclk; one stage of history for edges
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            // Idle bus floats high
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    // Bus conditions; data moving while the clock is high frames a transfer
    assign scl_rise = scl_in & ~scl_q;
    assign scl_fall = ~scl_in & scl_q;
    assign bus_start = scl_in & scl_q & sda_q & ~sda_in;
    assign bus_stop = scl_in & scl_q & ~sda_q & sda_in;

    // The data output is open drain, so only the enable ever moves
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    // Serial target: address, then pointer byte and write data, or read data straight after a read address
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            bit_cnt <= `BIT_CNT_ZERO;
            shift <= '0;
            reg_ptr <= '0;
            rw_read <= 1'b0;
            master_ack <= 1'b0;
            sda_oe_n <= 1'b1;
        end else if (bus_stop) begin
            // Stop always frees the line, whatever was in progress
            state <= ST_IDLE;
            sda_oe_n <= 1'b1;
        end else if (bus_start) begin
            // Repeated start keeps the pointer for a read after a write
            state <= ST_ADDR;
            bit_cnt <= `BIT_CNT_ZERO;
            sda_oe_n <= 1'b1;
        end else begin
            case (state)
                ST_IDLE: begin
                    // Wait for a start
                    sda_oe_n <= 1'b1;
                end
                ST_ADDR: begin
                    if (scl_rise) begin
                        shift <= {shift[6:0], sda_in};
                        bit_cnt <= bit_cnt + `BIT_CNT_STEP;
                    end else if (scl_fall && bit_cnt == `BYTE_BITS) begin
                        if (shift[7:1] == DEV_ADDR) begin
                            // Ours: acknowledge by pulling data low
                            rw_read <= shift[0];
                            sda_oe_n <= 1'b0;
                            state <= ST_ADDR_ACK;
                        end else begin
                            // Another target; stay off the line
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        bit_cnt <= `BIT_CNT_ZERO;
                        if (rw_read) begin
                            // Present the first bit of the addressed byte
                            shift <= rd_byte;
                            sda_oe_n <= rd_byte[7];
                            state <= ST_RDATA;
                        end else begin
                            sda_oe_n <= 1'b1;
                            state <= ST_REG;
                        end
                    end
                end
                ST_REG: begin
                    if (scl_rise) begin
                        shift <= {shift[6:0], sda_in};
                        bit_cnt <= bit_cnt + `BIT_CNT_STEP;
                    end else if (scl_fall && bit_cnt == `BYTE_BITS) begin
                        // Pointer byte; any value is accepted
                        reg_ptr <= shift;
                        sda_oe_n <= 1'b0;
                        state <= ST_REG_ACK;
                    end
                end
                ST_REG_ACK: begin
                    if (scl_fall) begin
                        bit_cnt <= `BIT_CNT_ZERO;
                        sda_oe_n <= 1'b1;
                        state <= ST_WDATA;
                    end
                end
                ST_WDATA: begin
                    if (scl_rise) begin
                        shift <= {shift[6:0], sda_in};
                        bit_cnt <= bit_cnt + `BIT_CNT_STEP;
                    end else if (scl_fall && bit_cnt == `BYTE_BITS) begin
                        // The write strobe fires on this same edge
                        reg_ptr <= reg_ptr + `PTR_STEP;
                        sda_oe_n <= 1'b0;
                        state <= ST_WDATA_ACK;
                    end
                end
                ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        bit_cnt <= `BIT_CNT_ZERO;
                        sda_oe_n <= 1'b1;
                        state <= ST_WDATA;
                    end
                end
                ST_RDATA: begin
                    if (scl_rise) begin
                        bit_cnt <= bit_cnt + `BIT_CNT_STEP;
                    end else if (scl_fall) begin
                        if (bit_cnt == `BYTE_BITS) begin
                            // Byte done; release for the host's answer
                            reg_ptr <= reg_ptr + `PTR_STEP;
                            sda_oe_n <= 1'b1;
                            state <= ST_RDATA_ACK;
                        end else begin
                            // Zero bits pull low, one bits release
                            shift <= {shift[6:0], 1'b0};
                            sda_oe_n <= shift[6];
                        end
                    end
                end
                ST_RDATA_ACK: begin
                    if (scl_rise) begin
                        master_ack <= ~sda_in;
                    end else if (scl_fall) begin
                        bit_cnt <= `BIT_CNT_ZERO;
                        if (master_ack) begin
                            // Host wants more: next register follows
                            shift <= rd_byte;
                            sda_oe_n <= rd_byte[7];
                            state <= ST_RDATA;
                        end else begin
                            // Not acknowledged: wait for stop
                            state <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    // Unused codes recover to idle
                    state <= ST_IDLE;
                    sda_oe_n <= 1'b1;
                end
            endcase
        end
    end

    // A register is written when the last data bit has been taken
    assign reg_write = (state == ST_WDATA) && scl_fall && (bit_cnt == `BYTE_BITS) &&
        !bus_start && !bus_stop;

    // Read decode; addresses outside the two masks read as zero
    always_comb begin
        case (reg_ptr)
            `CONV_MASK_ADDR: rd_byte = mask_reg[0];
            `LINREG_MASK_ADDR: rd_byte = mask_reg[1];
            default: rd_byte = `UNMAPPED_READ;
        endcase
    end

    // Mask registers; reserved positions are never stored
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            // All masks set: nothing interrupts until software opens it
            mask_reg[0] <= `MASK_RESET;
            mask_reg[1] <= `MASK_RESET;
        end else if (reg_write) begin
            if (reg_ptr == `CONV_MASK_ADDR) begin
                mask_reg[0] <= shift & `MASK_WRITABLE;
            end else if (reg_ptr == `LINREG_MASK_ADDR) begin
                mask_reg[1] <= shift & `MASK_WRITABLE;
            end
        end
    end

    // Live conditions are registered once; masks never touch them
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pg_raw_q <= '0;
            curlim_raw_q <= '0;
        end else begin
            pg_raw_q <= pg_invalid_in;
            curlim_raw_q <= curlim_active_in;
        end
    end

    // One detector per regulator; each picks its nibble of a mask register
    regulator_event_if ev [`NUM_REGULATORS] ();

    genvar r;
    generate
        for (r = 0; r < `NUM_REGULATORS; r++) begin : g_unit
            // Regulator 1 of a pair sits in the upper nibble
            localparam int REG_IDX = r / `UNITS_PER_REG;
            localparam int BASE = (r % `UNITS_PER_REG) * `UNIT_STRIDE;

            assign ev[r].pg_raw = pg_raw_q[r];
            assign ev[r].curlim_raw = curlim_raw_q[r];
            // Converter fields 7,6,4 and 3,2,0; same layout for linear ones
            assign ev[r].pg_fall_mask = mask_reg[REG_IDX][BASE + `BIT_PG_FALL];
            assign ev[r].pg_rise_mask = mask_reg[REG_IDX][BASE + `BIT_PG_RISE];
            assign ev[r].curlim_mask = mask_reg[REG_IDX][BASE + `BIT_CURLIM];

            regulator_event_detect u_detect (
                .mclk(mclk),
                .sys_rst(sys_rst),
                .ev(ev[r])
            );
        end
    endgenerate

    // Raw status outputs, unaffected by any mask
    assign conv0_pg_raw = pg_raw_q[0];
    assign conv1_pg_raw = pg_raw_q[1];
    assign linreg0_pg_raw = pg_raw_q[2];
    assign linreg1_pg_raw = pg_raw_q[3];
    assign conv0_curlim_raw = curlim_raw_q[0];
    assign conv1_curlim_raw = curlim_raw_q[1];
    assign linreg0_curlim_raw = curlim_raw_q[2];
    assign linreg1_curlim_raw = curlim_raw_q[3];

    // Interrupt requests; each is a detector flip-flop, pulsed for one cycle
    assign conv0_pg_irq = ev[0].pg_event;
    assign conv1_pg_irq = ev[1].pg_event;
    assign linreg0_pg_irq = ev[2].pg_event;
    assign linreg1_pg_irq = ev[3].pg_event;
    assign conv0_curlim_irq = ev[0].curlim_event;
    assign conv1_curlim_irq = ev[1].curlim_event;
    assign linreg0_curlim_irq = ev[2].curlim_event;
    assign linreg1_curlim_irq = ev[3].curlim_event;

    // Mask contents shown outside for the interrupt latch logic
    assign converter_irq_mask = mask_reg[0];
    assign linear_reg_irq_mask = mask_reg[1];
endmodule // regulator_irq_mask

// *** dv/regulator_irq_mask_monitor.sv ***
// Port-level assertions for the regulator interrupt masking block
`include "regulator_irq_params.svh"
module regulator_irq_mask_monitor (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [`NUM_REGULATORS-1:0] pg_invalid_in,
    input wire logic [`NUM_REGULATORS-1:0] curlim_active_in,
    input wire logic conv0_pg_raw,
    input wire logic conv1_pg_raw,
    input wire logic linreg0_pg_raw,
    input wire logic linreg1_pg_raw,
    input wire logic conv0_curlim_raw,
    input wire logic conv1_curlim_raw,
    input wire logic linreg0_curlim_raw,
    input wire logic linreg1_curlim_raw,
    input wire logic conv0_pg_irq,
    input wire logic conv1_pg_irq,
    input wire logic linreg0_pg_irq,
    input wire logic linreg1_pg_irq,
    input wire logic conv0_curlim_irq,
    input wire logic conv1_curlim_irq,
    input wire logic linreg0_curlim_irq,
    input wire logic linreg1_curlim_irq,
    input wire regulator_irq_pkg::byte_t converter_irq_mask,
    input wire regulator_irq_pkg::byte_t linear_reg_irq_mask
);
    timeunit 1ns;
    timeprecision 1ps;
    import regulator_irq_pkg::*;
    // Raw flags packed in the order of the live inputs
    wire logic [3:0] pg_raw_v = {linreg1_pg_raw, linreg0_pg_raw, conv1_pg_raw, conv0_pg_raw};
    wire logic [3:0] cl_raw_v = {linreg1_curlim_raw, linreg0_curlim_raw, conv1_curlim_raw,
        conv0_curlim_raw};
    wire byte_t cm = converter_irq_mask;  // Short aliases keep assertion lines narrow
    wire byte_t lm = linear_reg_irq_mask;

    default clocking mon_cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    // A raw edge pulses its request one cycle later only when its mask bit was clear
    property g_up(logic raw, logic irq, logic m);
        $rose(raw) |=> irq == !$past(m);
    endproperty
    property g_dn(logic raw, logic irq, logic m);
        $fell(raw) |=> irq == !$past(m);
    endproperty

    // Raw status ignores masks; guarded so inputs held during reset cannot trip it
    AST_PG_RAW:
        assert property ($past(sys_rst) || pg_raw_v == $past(pg_invalid_in)) else $error("pg");
    AST_CL_RAW:
        assert property ($past(sys_rst) || cl_raw_v == $past(curlim_active_in)) else $error("cl");
    AST_RESERVED:
        assert property ({cm[5], cm[1], lm[5], lm[1]} == 4'h0) else $error("reserved bit set");
    AST_CL_RELEASE:
        assert property ($fell(conv0_curlim_raw) |=> !conv0_curlim_irq) else $error("cl release");
    AST_C1_PGF:
        assert property (g_up(conv1_pg_raw, conv1_pg_irq, cm[7])) else $error("c1 fall");
    AST_C1_PGR:
        assert property (g_dn(conv1_pg_raw, conv1_pg_irq, cm[6])) else $error("c1 rise");
    AST_C1_CL:
        assert property (g_up(conv1_curlim_raw, conv1_curlim_irq, cm[4])) else $error("c1 cl");
    AST_C0_PGR:
        assert property (g_dn(conv0_pg_raw, conv0_pg_irq, cm[2])) else $error("c0 rise");
    AST_C0_CL:
        assert property (g_up(conv0_curlim_raw, conv0_curlim_irq, cm[0])) else $error("c0 cl");
    AST_L1_PGF:
        assert property (g_up(linreg1_pg_raw, linreg1_pg_irq, lm[7])) else $error("l1 fall");
    AST_L1_CL:
        assert property (g_up(linreg1_curlim_raw, linreg1_curlim_irq, lm[4])) else $error("l1 cl");
    AST_L0_PGR:
        assert property (g_dn(linreg0_pg_raw, linreg0_pg_irq, lm[2])) else $error("l0 rise");
    AST_L0_CL:
        assert property (g_up(linreg0_curlim_raw, linreg0_curlim_irq, lm[0])) else $error("l0 cl");

    // Main scenarios reached
    cover property ($rose(conv0_pg_raw) ##1 conv0_pg_irq);
    cover property ($rose(linreg1_curlim_raw) ##1 linreg1_curlim_irq);
    cover property ($fell(conv1_pg_raw) ##1 !conv1_pg_irq);
endmodule  // regulator_irq_mask_monitor

// *** dv/regulator_irq_mask_test.sv ***
// Self-checking bench for the regulator interrupt masking block
module regulator_irq_mask_test;
    timeunit 1ns;
    timeprecision 1ps;
    import regulator_irq_pkg::*;

    localparam logic [6:0] DEV = 7'h60;  // Target address, arbitrary
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic scl = 1'b1;  // Host serial clock
    logic sda_drv = 1'b1;  // Host side of the data line, 1 releases it
    logic [3:0] pg_in = 4'h0;  // Live power-good invalid per regulator
    logic [3:0] cl_in = 4'h0;  // Live current limit per regulator
    wire logic sda_out, sda_oe_n;
    wire logic [3:0] pg_raw, cl_raw, pg_irq, cl_irq;
    byte_t conv_mask, lin_mask;
    logic [7:0] irq_seen = 8'h00;  // Requests since last clear, current limit in upper half
    int pulse_cnt = 0;  // Every request pulse since start
    int bad_count = 0;
    int comparisons = 0;
    // Open drain: low whenever either party pulls it
    wire logic sda_wire = sda_drv & (sda_oe_n | sda_out);

    regulator_irq_mask #(.DEV_ADDR(DEV)) dut_u (
        .mclk(mclk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .pg_invalid_in(pg_in), .curlim_active_in(cl_in),
        .conv0_pg_raw(pg_raw[0]), .conv1_pg_raw(pg_raw[1]),
        .linreg0_pg_raw(pg_raw[2]), .linreg1_pg_raw(pg_raw[3]),
        .conv0_curlim_raw(cl_raw[0]), .conv1_curlim_raw(cl_raw[1]),
        .linreg0_curlim_raw(cl_raw[2]), .linreg1_curlim_raw(cl_raw[3]),
        .conv0_pg_irq(pg_irq[0]), .conv1_pg_irq(pg_irq[1]),
        .linreg0_pg_irq(pg_irq[2]), .linreg1_pg_irq(pg_irq[3]),
        .conv0_curlim_irq(cl_irq[0]), .conv1_curlim_irq(cl_irq[1]),
        .linreg0_curlim_irq(cl_irq[2]), .linreg1_curlim_irq(cl_irq[3]),
        .converter_irq_mask(conv_mask), .linear_reg_irq_mask(lin_mask)
    );

    // Free-running 50 MHz clock
    initial forever #10 mclk = ~mclk;

    // Tallies pulses before each edge's updates land, so no ordering race
    always @(posedge mclk) begin
        pulse_cnt += $countones({cl_irq, pg_irq});
        irq_seen |= {cl_irq, pg_irq};
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s: saw %h want %h", $time, what, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Three clocks per serial phase keeps every phase above the two-clock minimum
    task automatic half();
        repeat (3) @(posedge mclk);
    endtask

    task automatic start_cond();
        sda_drv <= 1'b1;
        half();
        scl <= 1'b1;
        half();
        sda_drv <= 1'b0;
        half();
        scl <= 1'b0;
        half();
    endtask

    task automatic stop_cond();
        sda_drv <= 1'b0;
        half();
        scl <= 1'b1;
        half();
        sda_drv <= 1'b1;
        half();
    endtask

    // Eight bits MSB first plus the ninth, sampling the wire on every high phase
    task automatic xbyte(input byte_t tx, input logic nine, output byte_t rx, output logic ack);
        logic [8:0] out_bits;
        logic [8:0] in_bits;
        out_bits = {tx, nine};
        for (int i = 8; i >= 0; i--) begin
            sda_drv <= out_bits[i];
            half();
            scl <= 1'b1;
            half();
            in_bits[i] = sda_wire;
            scl <= 1'b0;
            half();
        end
        rx = in_bits[8:1];
        ack = in_bits[0];
    endtask

    // Register write, or pointer write then repeated-start read ended by a NACK
    task automatic access(input logic wr, input byte_t addr, input byte_t wdata,
                          output byte_t rdata);
        byte_t rx;
        logic ack;
        start_cond();
        xbyte({DEV, 1'b0}, 1'b1, rx, ack);
        check({7'h00, ack}, 8'h00, "address not acked");
        xbyte(addr, 1'b1, rx, ack);
        if (wr) begin
            xbyte(wdata, 1'b1, rx, ack);
        end else begin
            start_cond();
            xbyte({DEV, 1'b1}, 1'b1, rx, ack);
            xbyte(8'hFF, 1'b1, rdata, ack);
        end
        stop_cond();
    endtask

    task automatic reset_values();
        byte_t rx;
        check(conv_mask, 8'hDD, "conv reset");
        check(lin_mask, 8'hDD, "lin reset");
        check({pg_raw, cl_raw}, 8'h00, "raw after reset");
        access(1'b0, 8'h22, 8'h00, rx);
        check(rx, 8'hDD, "converter mask read");
        access(1'b0, 8'h23, 8'h00, rx);
        check(rx, 8'hDD, "linear mask read");
        $display("reset_values done");
    endtask

    // Write, then read the same or the other register: reserved bits, register isolation, an unowned address
    task automatic reg_access();
        byte_t tbl [5][4] = '{'{8'h22, 8'hFF, 8'h22, 8'hDD}, '{8'h23, 8'hFF, 8'h23, 8'hDD},
            '{8'h22, 8'h00, 8'h23, 8'hDD}, '{8'h23, 8'h00, 8'h22, 8'h00},
            '{8'h24, 8'h5A, 8'h24, 8'h00}};
        byte_t rx;
        logic ack;
        foreach (tbl[i]) begin
            access(1'b1, tbl[i][0], tbl[i][1], rx);
            access(1'b0, tbl[i][2], 8'h00, rx);
            check(rx, tbl[i][3], "read back");
        end
        check(conv_mask | lin_mask, 8'h00, "mask ports");
        start_cond();
        xbyte({DEV ^ 7'h01, 1'b0}, 1'b1, rx, ack);
        check({7'h00, ack}, 8'h01, "foreign address acked");
        stop_cond();
        access(1'b1, 8'h22, 8'hDD, rx);
        access(1'b1, 8'h23, 8'hDD, rx);
        $display("reg_access done");
    endtask

    // Kind 0 goes invalid, 1 goes valid, 2 enters current limit, on unit u with mask bit m
    task automatic one_event(input int u, input int k, input logic m);
        byte_t val;
        byte_t rx;
        int base;
        val = 8'hDD;
        val[(u % 2) * 4 + (k == 0 ? 3 : (k == 1 ? 2 : 0))] = m;
        pg_in[u] <= (k == 1);  // A valid transition needs an invalid start
        half();
        access(1'b1, (u < 2) ? 8'h22 : 8'h23, val, rx);
        if (k == 2) begin
            cl_in[u] <= 1'b1;
        end else begin
            pg_in[u] <= (k == 0);
        end
        #1;
        base = pulse_cnt;
        irq_seen = 8'h00;
        repeat (4) @(posedge mclk);
        #1;
        check(8'(pulse_cnt - base), {7'h00, !m}, "request count");
        check(irq_seen, m ? 8'h00 : 8'h01 << (k == 2 ? u + 4 : u), "source");
        check(8'({pg_raw[u], cl_raw[u]}), 8'({k == 0, k == 2}), "raw");
        @(posedge mclk);
        access(1'b1, (u < 2) ? 8'h22 : 8'h23, 8'hDD, rx);
        pg_in[u] <= 1'b0;
        cl_in[u] <= 1'b0;
        half();
    endtask

    task automatic gating_all();
        for (int u = 0; u < 4; u++) begin
            for (int k = 0; k < 3; k++) begin
                one_event(u, k, 1'b0);
                one_event(u, k, 1'b1);
            end
        end
        $display("gating_all done");
    endtask

    // Unmasking over a standing condition raises nothing; each back-to-back change does
    task automatic mask_write_quiet();
        byte_t rx;
        int base;
        pg_in[0] <= 1'b1;
        half();
        base = pulse_cnt;
        access(1'b1, 8'h22, 8'h00, rx);
        half();
        check(8'(pulse_cnt - base), 8'h00, "request on mask write");
        base = pulse_cnt;
        repeat (4) begin
            pg_in[0] <= ~pg_in[0];
            @(posedge mclk);
        end
        repeat (4) @(posedge mclk);
        #1;
        check(8'(pulse_cnt - base), 8'h04, "toggle requests");
        @(posedge mclk);
        access(1'b1, 8'h22, 8'hDD, rx);
        $display("mask_write_quiet done");
    endtask

    // Main sequence: reset for 16 clocks, then each scenario
    initial begin
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        half();
        reset_values();
        reg_access();
        gating_all();
        mask_write_quiet();
        end_of_test();
    end

    // Watchdog, about three times the expected run
    initial begin
        repeat (60000) @(posedge mclk);
        bad_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        end_of_test();
    end
endmodule  // regulator_irq_mask_test

bind regulator_irq_mask regulator_irq_mask_monitor mon_u (
    .mclk, .sys_rst, .pg_invalid_in, .curlim_active_in,
    .conv0_pg_raw, .conv1_pg_raw, .linreg0_pg_raw, .linreg1_pg_raw,
    .conv0_curlim_raw, .conv1_curlim_raw, .linreg0_curlim_raw, .linreg1_curlim_raw,
    .conv0_pg_irq, .conv1_pg_irq, .linreg0_pg_irq, .linreg1_pg_irq,
    .conv0_curlim_irq, .conv1_curlim_irq, .linreg0_curlim_irq, .linreg1_curlim_irq,
    .converter_irq_mask, .linear_reg_irq_mask
);
